// ==== shared/cms_cfg.svh ====
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH
// ==========================================================
// mailbox store layout
`define CMS_NUM_MBOX      16
`define CMS_BYTES_PER_SET 8
`define CMS_ADDR_W        8
// address bit 7 picks payload set, bits 6:3 mailbox, 2:0 byte
`define CMS_SEL_BIT       7
`define CMS_MBOX_HI       6
`define CMS_MBOX_LO       3
`define CMS_BYTE_HI       2
`define CMS_BYTE_LO       0
// control byte indices (zero based)
`define CMS_CB_LEN        3'h0
`define CMS_CB_FLAGS      3'h4
`define CMS_CB_TOP        3'h5
`define CMS_CB_LOW        3'h6
`define CMS_CB_MID        3'h7
// field positions
`define CMS_LEN_HI        3
`define CMS_RTR_BIT       4
`define CMS_IDE_BIT       3
// identifier bit groups inside the flags byte
`define CMS_ID20_HI       7
`define CMS_ID20_LO       5
`define CMS_ID17_HI       1
`define CMS_ID17_LO       0
`define CMS_MAX_LEN       4'h8
`define CMS_ZERO_BYTE     8'h00
`define CMS_ZERO_ID       29'h0000_0000
`endif

// ==== shared/cms_pkg.sv ====
package cms_pkg;
  typedef logic [7:0]  cms_byte_t;
  typedef logic [28:0] cms_id_t;
  typedef logic [3:0]  cms_len_t;
  typedef enum logic [1:0] {CMS_IDLE, CMS_READ, CMS_WRITE} cms_acc_t;
endpackage : cms_pkg

// ==== rtl/cms_byte_ram.sv ====
`timescale 1ns/1ps
// storage without reset: contents survive a hardware reset
module cms_byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  // ==========================================================
  // write port, no reset so software must initialise each byte
  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];
endmodule : cms_byte_ram

// ==== rtl/cms_mailbox_store.sv ====
// Operation
// R1: sixteen mailboxes, each with eight read/write control bytes
// R2: control bytes power up undefined; software initialises every bit
// R3: low nibble of first control byte is length code 0 to 8
// R4: codes above eight mean eight bytes; high nibble is spare storage
// R5: fifth byte bit 4 selects data or remote frame
// R6: fifth byte bit 3 selects standard or extended identifier
// R7: fifth byte holds id 20..18 at 7..5, id 17..16 at 1..0
// R8: sixth byte holds id 28..21
// R9: seventh byte id 7..0, eighth byte id 15..8
// R10: sixteen mailboxes each with eight payload bytes
// R11: payload bytes power up undefined; software writes them first
// R12: hardware reset clears internal registers, not mailbox storage
// R13: payload sent in ascending order; standard uses id 28..18 only
// R14: second to fourth control bytes are plain storage
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "cms_cfg.svh"
module cms_mailbox_store
  import cms_pkg::*;
#(
  parameter int NUM_MBOX = `CMS_NUM_MBOX,
  parameter int MBOX_W   = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   ce_i,
  // software register port
  input  wire logic [`CMS_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  // protocol engine: frame fetch
  input  wire logic                   pe_fetch_i,
  input  wire logic [MBOX_W-1:0]      pe_fetch_mbox_i,
  output logic                        pe_hdr_valid_o,
  output logic      [28:0]            pe_id_o,
  output logic                        pe_ide_o,
  output logic                        pe_rtr_o,
  output logic      [3:0]             pe_len_o,
  // protocol engine: payload byte stream
  output logic                        pe_byte_valid_o,
  output logic      [7:0]             pe_byte_o,
  output logic                        pe_byte_last_o,
  // protocol engine: payload store on reception
  input  wire logic                   pe_store_i,
  input  wire logic [MBOX_W-1:0]      pe_store_mbox_i,
  input  wire logic [2:0]             pe_store_idx_i,
  input  wire logic [7:0]             pe_store_byte_i
);

  // ==========================================================
  // helpers
  // R4: clamp length code
  function automatic cms_len_t eff_len(input cms_byte_t b);
    cms_len_t c;
    c = b[`CMS_LEN_HI:0];
    eff_len = (c > `CMS_MAX_LEN) ? `CMS_MAX_LEN : c;
  endfunction : eff_len

  function automatic logic [7:0] ram_addr(input logic sel, input logic [MBOX_W-1:0] mb,
                                          input logic [2:0] idx);
    ram_addr = {sel, mb, idx};
  endfunction : ram_addr

  // ==========================================================
  // fetch sequencer state
  typedef enum logic [1:0] {CMS_F_IDLE, CMS_F_HDR, CMS_F_DATA} cms_fst_t;
  cms_fst_t          fst, next_fst;
  logic [MBOX_W-1:0] fmb, next_fmb;
  logic [2:0]        fidx, next_fidx;
  cms_byte_t         len_b, next_len_b;
  cms_byte_t         flags_b, next_flags_b;
  cms_byte_t         top_b, next_top_b;
  cms_byte_t         low_b, next_low_b;
  logic [2:0]        hcnt, next_hcnt;
  cms_len_t          remain, next_remain;

  // ==========================================================
  // ram port arbitration: software first, then receive store, then fetch
  logic       ram_we;
  logic [7:0] ram_waddr, ram_raddr, ram_q;
  cms_byte_t  ram_wdata;
  logic       sw_rd_pend, next_sw_rd_pend;
  cms_byte_t  rdata, next_rdata;

  // R1: software writes reach any control byte
  // R10: and any payload byte
  // R14: spare control bytes stored like any other
  always_comb
  begin
    ram_we    = 1'b0;
    ram_waddr = addr_i;
    ram_wdata = wdata_i;
    if (wr_i)
    begin
      ram_we = 1'b1;
    end
    // R13: received payload byte stored at its ascending index
    else if (pe_store_i)
    begin
      ram_we    = 1'b1;
      ram_waddr = ram_addr(1'b1, pe_store_mbox_i, pe_store_idx_i);
      ram_wdata = pe_store_byte_i;
    end
  end

  // read address: software read wins, else the fetch sequencer
  always_comb
  begin
    ram_raddr = addr_i;
    if (!rd_i)
    begin
      if (fst == CMS_F_HDR)
      begin
        ram_raddr = ram_addr(1'b0, fmb, hcnt);
      end
      else
      begin
        ram_raddr = ram_addr(1'b1, fmb, fidx);
      end
    end
  end

  // R12: storage has no reset, only the read data register and the sequencer below do
  cms_byte_ram #(
    .DEPTH (1 << `CMS_ADDR_W),
    .AW    (`CMS_ADDR_W)
  ) u_ram (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (ram_raddr),
    .rdata_o (ram_q)
  );

  // ==========================================================
  // software read data, one cycle after the strobe
  always_comb
  begin
    next_rdata      = rdata;
    next_sw_rd_pend = rd_i;
    if (rd_i)
    begin
      next_rdata = ram_q;
    end
    else if (sw_rd_pend)
    begin
      next_rdata = `CMS_ZERO_BYTE;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata      <= `CMS_ZERO_BYTE;
      sw_rd_pend <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata      <= next_rdata;
      sw_rd_pend <= next_sw_rd_pend;
    end
  end

  // ==========================================================
  // fetch sequencer: header bytes then payload bytes in order
  // stalls a cycle whenever software reads during a header or payload byte fetch, since reads share the port
  logic      hdr_v, next_hdr_v, byte_v, next_byte_v, byte_last, next_byte_last;
  cms_byte_t pbyte, next_pbyte;
  cms_id_t   pid, next_pid;
  logic      pide, next_pide, prtr, next_prtr;
  cms_len_t  plen, next_plen;

  always_comb
  begin
    next_fst       = fst;
    next_fmb       = fmb;
    next_fidx      = fidx;
    next_len_b     = len_b;
    next_flags_b   = flags_b;
    next_top_b     = top_b;
    next_low_b     = low_b;
    next_hcnt      = hcnt;
    next_remain    = remain;
    next_hdr_v     = 1'b0;
    next_byte_v    = 1'b0;
    next_byte_last = 1'b0;
    next_pbyte     = pbyte;
    next_pid       = pid;
    next_pide      = pide;
    next_prtr      = prtr;
    next_plen      = plen;
    case (fst)
      CMS_F_IDLE:
      begin
        if (pe_fetch_i)
        begin
          next_fst  = CMS_F_HDR;
          next_fmb  = pe_fetch_mbox_i;
          next_hcnt = `CMS_CB_LEN;
        end
      end
      CMS_F_HDR:
      begin
        if (!rd_i)
        begin
          case (hcnt)
            `CMS_CB_LEN:   next_len_b   = ram_q;
            `CMS_CB_FLAGS: next_flags_b = ram_q;
            `CMS_CB_TOP:   next_top_b   = ram_q;
            `CMS_CB_LOW:   next_low_b   = ram_q;
            default:       next_hcnt    = hcnt;
          endcase
          next_hcnt = hcnt + 3'h1;
          if (hcnt == `CMS_CB_MID)
          begin
            next_hdr_v = 1'b1;
            // R5: frame type bit
            next_prtr  = flags_b[`CMS_RTR_BIT];
            // R6: identifier format bit
            next_pide  = flags_b[`CMS_IDE_BIT];
            // R8: top byte is id 28..21
            // R7: flags byte carries id 20..16
            // R9: mid byte id 15..8, low byte id 7..0
            // R13: standard format keeps only id 28..18
            if (flags_b[`CMS_IDE_BIT])
            begin
              next_pid = {top_b, flags_b[`CMS_ID20_HI:`CMS_ID20_LO], flags_b[`CMS_ID17_HI:`CMS_ID17_LO],
                          ram_q, low_b};
            end
            else
            begin
              next_pid = {top_b, flags_b[`CMS_ID20_HI:`CMS_ID20_LO], 18'h0_0000};
            end
            // R3: length code
            // R4: clamped to eight
            next_plen   = eff_len(len_b);
            next_remain = flags_b[`CMS_RTR_BIT] ? 4'h0 : eff_len(len_b);
            next_fidx   = 3'h0;
            next_fst    = CMS_F_DATA;
          end
        end
      end
      CMS_F_DATA:
      begin
        if (remain == 4'h0)
        begin
          next_fst = CMS_F_IDLE;
        end
        else if (!rd_i)
        begin
          // R13: payload bytes in ascending order
          next_byte_v    = 1'b1;
          next_pbyte     = ram_q;
          next_byte_last = (remain == 4'h1);
          next_fidx      = fidx + 3'h1;
          next_remain    = remain - 4'h1;
        end
      end
      default:
      begin
        next_fst = CMS_F_IDLE;
      end
    endcase
  end

  // R12: sequencer flops are reset, as is the read data register above
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fst       <= CMS_F_IDLE;
      fmb       <= '0;
      fidx      <= 3'h0;
      len_b     <= `CMS_ZERO_BYTE;
      flags_b   <= `CMS_ZERO_BYTE;
      top_b     <= `CMS_ZERO_BYTE;
      low_b     <= `CMS_ZERO_BYTE;
      hcnt      <= 3'h0;
      remain    <= 4'h0;
      hdr_v     <= 1'b0;
      byte_v    <= 1'b0;
      byte_last <= 1'b0;
      pbyte     <= `CMS_ZERO_BYTE;
      pid       <= `CMS_ZERO_ID;
      pide      <= 1'b0;
      prtr      <= 1'b0;
      plen      <= 4'h0;
    end
    else if (ce_i)
    begin
      fst       <= next_fst;
      fmb       <= next_fmb;
      fidx      <= next_fidx;
      len_b     <= next_len_b;
      flags_b   <= next_flags_b;
      top_b     <= next_top_b;
      low_b     <= next_low_b;
      hcnt      <= next_hcnt;
      remain    <= next_remain;
      hdr_v     <= next_hdr_v;
      byte_v    <= next_byte_v;
      byte_last <= next_byte_last;
      pbyte     <= next_pbyte;
      pid       <= next_pid;
      pide      <= next_pide;
      prtr      <= next_prtr;
      plen      <= next_plen;
    end
  end

  assign rdata_o         = rdata;
  assign pe_hdr_valid_o  = hdr_v;
  assign pe_id_o         = pid;
  assign pe_ide_o        = pide;
  assign pe_rtr_o        = prtr;
  assign pe_len_o        = plen;
  assign pe_byte_valid_o = byte_v;
  assign pe_byte_o       = pbyte;
  assign pe_byte_last_o  = byte_last;

  // ==========================================================
  // checks
  sequence s_hdr_out;
    pe_hdr_valid_o;
  endsequence

  a_len_clamp: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    s_hdr_out |-> pe_len_o <= `CMS_MAX_LEN) else $error("length above eight");

  a_std_id_low: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    s_hdr_out and !pe_ide_o |-> pe_id_o[17:0] == 18'h0_0000) else $error("standard id low bits set");

  a_remote_nodata: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R5
    s_hdr_out and pe_rtr_o |-> ##1 !pe_byte_valid_o ##1 !pe_byte_valid_o) else $error("remote frame sent payload");

  a_read_lat: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    ce_i && rd_i |=> rdata_o == $past(ram_q)) else $error("read data wrong");

  a_last_single: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    pe_byte_last_o |-> pe_byte_valid_o) else $error("last without valid");

  a_ide_track: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R6
    s_hdr_out |-> pe_ide_o == flags_b[`CMS_IDE_BIT]) else $error("format bit mismatch");

  a_top_id: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
    s_hdr_out |-> pe_id_o[28:21] == top_b) else $error("top id byte mismatch");

  a_mid_id: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
    s_hdr_out |-> pe_id_o[20:18] == flags_b[`CMS_ID20_HI:`CMS_ID20_LO]) else $error("id 20..18 mismatch");

endmodule : cms_mailbox_store

// ==== tb/cms_pe_model.sv ====
`timescale 1ns/1ps
// protocol engine stand-in: asks for frames, collects the byte stream
module cms_pe_model (
  input  wire logic       clk_i,
  output logic            fetch_o,
  output logic [3:0]      fetch_mbox_o,
  output logic            store_o,
  output logic [3:0]      store_mbox_o,
  output logic [2:0]      store_idx_o,
  output logic [7:0]      store_byte_o,
  input  wire logic       hdr_valid_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       byte_last_i
);
  int         n_hdr  = 0;
  int         n_last = 0;
  logic [7:0] rx_q[$];
  initial
  begin
    {fetch_o, fetch_mbox_o, store_o, store_mbox_o, store_idx_o, store_byte_o} = '0;
  end
  // a new header opens a fresh frame, so stale bytes never count twice
  always @(posedge clk_i)
  begin
    if (hdr_valid_i)
    begin
      n_hdr++;
      rx_q = {};
    end
    if (byte_valid_i) rx_q.push_back(byte_i);
    if (byte_last_i) n_last++;
  end
  task automatic fetch(input logic [3:0] m);
    @(posedge clk_i);
    fetch_o      <= 1'b1;
    fetch_mbox_o <= m;
    @(posedge clk_i);
    fetch_o      <= 1'b0;
    fetch_mbox_o <= ~m; // qualifier garbled once released
  endtask : fetch
  task automatic store(input logic [3:0] m, input logic [2:0] i, input logic [7:0] b);
    @(posedge clk_i);
    store_o      <= 1'b1;
    store_mbox_o <= m;
    store_idx_o  <= i;
    store_byte_o <= b;
    @(posedge clk_i);
    store_o      <= 1'b0;
    store_byte_o <= ~b;
  endtask : store
endmodule : cms_pe_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import cms_pkg::*;
  logic      clk_i     = 1'b0;
  logic      reset_n_i = 1'b0;
  logic      ce_i      = 1'b1;
  logic [7:0] addr_i   = 8'h00;
  cms_byte_t wdata_i   = 8'h00;
  logic      wr_i      = 1'b0;
  logic      rd_i      = 1'b0;
  cms_byte_t rdata_o, sbyte, pb;
  logic      fetch, store, hdr_v, ide, rtr, bv, blast;
  logic [3:0] fmb, smb;
  logic [2:0] sidx;
  cms_id_t   id;
  cms_len_t  len;
  int        failures = 0;
  int        n_tests  = 0;
  int        cyc      = 0;
  always #25 clk_i = ~clk_i;
  cms_mailbox_store u_cms_mailbox_store (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pe_fetch_i(fetch), .pe_fetch_mbox_i(fmb), .pe_hdr_valid_o(hdr_v), .pe_id_o(id),
    .pe_ide_o(ide), .pe_rtr_o(rtr), .pe_len_o(len), .pe_byte_valid_o(bv), .pe_byte_o(pb),
    .pe_byte_last_o(blast), .pe_store_i(store), .pe_store_mbox_i(smb),
    .pe_store_idx_i(sidx), .pe_store_byte_i(sbyte));
  cms_pe_model u_cms_pe_model (.clk_i(clk_i), .fetch_o(fetch), .fetch_mbox_o(fmb),
    .store_o(store), .store_mbox_o(smb), .store_idx_o(sidx), .store_byte_o(sbyte),
    .hdr_valid_i(hdr_v), .byte_valid_i(bv), .byte_i(pb), .byte_last_i(blast));
  // ==========================================
  // helpers
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] ad(input int s, input int m, input int i);
    return {s[0], m[3:0], i[2:0]};
  endfunction : ad
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    wdata_i <= ~d;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(nm, {24'h0, exp}, {24'h0, rdata_o});
  endtask : rd
  // ==========================================
  // scenarios
  task automatic t_fill_reset;
    for (int m = 0; m < 16; m++)
      for (int i = 0; i < 8; i++)
      begin
        wr(ad(0, m, i), {m[3:0], 1'b0, i[2:0]} ^ 8'ha5);
        wr(ad(1, m, i), {~m[3:0], 1'b1, i[2:0]});
      end
    // a second reset must leave every stored byte alone
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int m = 0; m < 16; m++)
      for (int i = 0; i < 8; i++)
      begin
        rd(ad(0, m, i), {m[3:0], 1'b0, i[2:0]} ^ 8'ha5, "ctrl");
        rd(ad(1, m, i), {~m[3:0], 1'b1, i[2:0]}, "data");
      end
    $display("test fill_reset done");
  endtask : t_fill_reset
  task automatic t_store;
    u_cms_pe_model.store(4'h9, 3'h3, 8'h3c);
    rd(ad(1, 9, 3), 8'h3c, "stored");
    fork
      wr(ad(1, 9, 5), 8'h77);
      u_cms_pe_model.store(4'h9, 3'h5, 8'h88);
    join
    rd(ad(1, 9, 5), 8'h77, "sw wins");
    // clock enable low: a write must leave the byte alone
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(ad(1, 9, 5), 8'h11);
    ce_i <= 1'b1;
    rd(ad(1, 9, 5), 8'h77, "frozen");
    $display("test store done");
  endtask : t_store
  // one frame per length code; odd codes extended, code 5 remote
  task automatic t_frame(input logic [3:0] c);
    cms_id_t  v;
    logic     x, r;
    cms_len_t el;
    int       n, h, l;
    v  = 29'h15a3_c96e ^ {25'h0, c};
    x  = c[0];
    r  = (c == 4'h5);
    el = (c > 4'h8) ? 4'h8 : c;
    n  = r ? 0 : el;
    wr(ad(0, c, 0), {4'h9, c});
    wr(ad(0, c, 4), {v[20:18], r, x, 1'b0, v[17:16]});
    wr(ad(0, c, 5), v[28:21]);
    wr(ad(0, c, 6), v[7:0]);
    wr(ad(0, c, 7), v[15:8]);
    for (int k = 0; k < 8; k++) wr(ad(1, c, k), {c, 1'b1, k[2:0]});
    h = u_cms_pe_model.n_hdr;
    l = u_cms_pe_model.n_last;
    u_cms_pe_model.fetch(c);
    // a software read in mid fetch stalls the sequencer for a cycle
    rd(ad(0, c, 0), {4'h9, c}, "rd busy");
    for (int w = 0; w < 40 && u_cms_pe_model.n_hdr == h; w++) @(posedge clk_i);
    repeat (12) @(posedge clk_i);
    chk("hdr", 1, u_cms_pe_model.n_hdr - h);
    chk("id", x ? v : {v[28:18], 18'h0}, id);
    chk("ide", x, ide);
    chk("rtr", r, rtr);
    chk("len", el, len);
    chk("count", n, u_cms_pe_model.rx_q.size());
    chk("last", n > 0, u_cms_pe_model.n_last - l);
    for (int k = 0; k < n && k < u_cms_pe_model.rx_q.size(); k++)
      chk("byte", {c, 1'b1, k[2:0]}, u_cms_pe_model.rx_q[k]);
    $display("test frame %0d done", c);
  endtask : t_frame
  // ==========================================
  // sequence and hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      stop_test;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // software writes every byte before any use
    t_fill_reset;
    t_store;
    for (int c = 0; c < 16; c++) t_frame(c[3:0]);
    stop_test;
  end
endmodule : tb_top
